// ==== common/tse_pkg.sv ====
// package: widths, layout constants and carrier types of the tcm secded path
package tse_pkg;

    // =====================================================================
    // word and code geometry
    localparam int DATA_W  = 64;              // logical data word
    localparam int CODE_W  = 8;               // check code stored beside it
    localparam int CW_W    = DATA_W + CODE_W; // full codeword, 72 bits
    localparam int SYN_W   = 7;               // hamming syndrome width
    localparam int NBANK   = 2;               // physical banks per word
    localparam int BANK_W  = CW_W / NBANK;    // 36 cells per bank row
    localparam int ILV_GRP = 4;               // column groups inside a bank
    localparam int ILV_LEN = BANK_W / ILV_GRP;

    // =====================================================================
    // timing: request at edge 0, bank data at edge 1, answer at edge 2
    localparam int RD_LATENCY = 2;

    // =====================================================================
    // severity encodings toward the error aggregation unit
    localparam logic [1:0] SEV_NONE = 2'h0;
    localparam logic [1:0] SEV_LOW  = 2'h1;   // corrected single-bit
    localparam logic [1:0] SEV_HIGH = 2'h2;   // uncorrectable double-bit

    // =====================================================================
    // which memory this instance guards
    typedef enum logic [1:0] {
        TSE_MAIN_TCM,
        TSE_MONITOR_TCM,
        TSE_PERIPH_SRAM
    } tse_class_t;

    // request from the processor core
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [15:0]       addr;
        logic [DATA_W-1:0] wdata;
    } tse_req_t;

    // answer to the processor core
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
        logic              sbe;
        logic              dbe;
        logic              abort;
    } tse_rsp_t;

    // static configuration from the core's own control logic
    typedef struct packed {
        logic       sbe_abort_en;   // single-bit error answers with abort
        logic       dbe_abort_en;   // double-bit error answers with abort
        logic       periph_en;      // protection enabled in the peripheral
        logic       agg_en;         // protection enabled in the aggregator
        logic [1:0] agg_resp_mask;  // per severity: raise aggregator interrupt
    } tse_cfg_t;

    // event pulses leaving the block
    typedef struct packed {
        logic       agg_sbe;        // to error aggregation unit
        logic       agg_dbe;
        logic [1:0] agg_sev;        // severity class of the pulse
        logic       agg_irq;        // programmed response: main_processor irq
        logic       mon_sbe;        // to monitor_processor
        logic       main_dbe_irq;   // to main_processor
    } tse_evt_t;

    // complete state of the checker
    typedef struct packed {
        logic rd_pend;
        tse_rsp_t rsp;
        tse_evt_t evt;
    } tse_state_t;

    localparam tse_state_t STATE_RST = '0;

endpackage : tse_pkg

// ==== verilog/tse_sram_bank.sv ====
// file: one physical sram bank with registered read data
`timescale 1ns/1ns
module tse_sram_bank #(
    parameter int W     = 36,
    parameter int AW    = 10
) (
    input  wire logic          ref_clk,
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [W-1:0]  wdata,
    output logic      [W-1:0]  rdata_q
);
    // =====================================================================
    // storage
    logic [W-1:0] mem [0:(1<<AW)-1];

    // array contents are not reset; read data leaves through a register
    always_ff @(posedge ref_clk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata_q <= mem[addr];
        end
    end
endmodule : tse_sram_bank

// ==== verilog/tse_ecc_path.sv ====
// file: secded codec, bank split and bit interleave between core and sram
`timescale 1ns/1ns
module tse_ecc_path
    import tse_pkg::*;
#(
    parameter int         ADDR_W    = 10,
    parameter tse_class_t MEM_CLASS = TSE_MAIN_TCM
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire tse_pkg::tse_req_t req,
    output logic               req_ready,
    input  wire tse_pkg::tse_cfg_t cfg,
    output tse_pkg::tse_rsp_t  rsp,
    output tse_pkg::tse_evt_t  evt
);
    import tse_pkg::*;

    // =====================================================================
    // hamming helpers: codeword bit p (1..71) is a parity bit when p is a
    // power of two, otherwise a data bit; bit 0 is overall parity

    // syndrome over positions 1..71 of a codeword
    function automatic logic [SYN_W-1:0] syn_of(input logic [CW_W-1:0] c);
        logic [SYN_W-1:0] s;
        s = '0;
        for (int p = 1; p < CW_W; p++) begin
            for (int k = 0; k < SYN_W; k++) begin
                if (p[k]) begin
                    s[k] = s[k] ^ c[p];
                end
            end
        end
        return s;
    endfunction : syn_of

    // true for positions that hold check bits
    function automatic logic is_chk(input int p);
        return (p == 0) || ((p & (p - 1)) == 0);
    endfunction : is_chk

    // data plus code into one 72-bit codeword
    function automatic logic [CW_W-1:0] encode(input logic [DATA_W-1:0] d);
        logic [CW_W-1:0]  c;
        logic [SYN_W-1:0] s;
        int               j;
        c = '0;
        j = 0;
        for (int p = 1; p < CW_W; p++) begin
            if (!is_chk(p)) begin
                c[p] = d[j];
                j++;
            end
        end
        s = syn_of(c);
        for (int k = 0; k < SYN_W; k++) begin
            c[1 << k] = s[k];
        end
        c[0] = ^c[CW_W-1:1];
        return c;
    endfunction : encode

    // data bits out of a codeword
    function automatic logic [DATA_W-1:0] extract(input logic [CW_W-1:0] c);
        logic [DATA_W-1:0] d;
        int                j;
        d = '0;
        j = 0;
        for (int p = 1; p < CW_W; p++) begin
            if (!is_chk(p)) begin
                d[j] = c[p];
                j++;
            end
        end
        return d;
    endfunction : extract

    // =====================================================================
    // bank split and interleave, hard-wired with no control input
    // even codeword bits go to bank 0, odd to bank 1; inside a bank the
    // cells are scattered in column groups so neighbours are far apart
    logic [CW_W-1:0]   wr_cw;
    logic [CW_W-1:0]   rd_cw;
    logic [BANK_W-1:0] bank_wdata [NBANK];
    logic [BANK_W-1:0] bank_rdata [NBANK];
    logic              bank_en;

    assign req_ready = 1'b1;                       // banks accept every cycle
    assign bank_en   = req.valid;
    assign wr_cw     = encode(req.wdata);

    genvar gb, gi;
    generate
        for (gb = 0; gb < NBANK; gb++) begin : g_bank
            for (gi = 0; gi < BANK_W; gi++) begin : g_cell
                // logical bit gi*2+gb lands in a distant physical column
                localparam int PHYS = (gi % ILV_GRP) * ILV_LEN + gi / ILV_GRP;
                assign bank_wdata[gb][PHYS] = wr_cw[gi*NBANK+gb];
                assign rd_cw[gi*NBANK+gb]   = bank_rdata[gb][PHYS];
            end
            // each bank decodes its own address; a decode fault in one
            // returns a half row from elsewhere and fails the check;
            // limitation: mixed halves escape only when they happen to
            // form a valid codeword, which some data pairs do
            tse_sram_bank #(
                .W  (BANK_W),
                .AW (ADDR_W)
            ) u_bank (
                .ref_clk (ref_clk),
                .en      (bank_en),
                .we      (req.write),
                .addr    (req.addr[ADDR_W-1:0]),
                .wdata   (bank_wdata[gb]),
                .rdata_q (bank_rdata[gb])
            );
        end
    endgenerate

    // =====================================================================
    // check of the returned codeword
    logic [SYN_W-1:0]  syn;
    logic              ovr;
    logic [CW_W-1:0]   fix_cw;
    logic              det_sbe;
    logic              det_dbe;
    logic              prot_on;
    logic [DATA_W-1:0] fix_data;

    // peripheral srams stay unprotected until both sides enable it
    assign prot_on = (MEM_CLASS != TSE_PERIPH_SRAM) || (cfg.periph_en && cfg.agg_en);

    // single: odd overall parity, syndrome below 72; double: even parity with nonzero syndrome, or odd parity with syndrome 72 or above
    always_comb begin
        syn     = syn_of(rd_cw);
        ovr     = ^rd_cw;
        fix_cw  = rd_cw;
        det_sbe = 1'b0;
        det_dbe = 1'b0;
        if (ovr) begin
            if (syn < SYN_W'(CW_W)) begin
                det_sbe             = 1'b1;
                fix_cw[syn]         = ~rd_cw[syn]; // syndrome 0 flips bit 0
            end else begin
                det_dbe             = 1'b1;        // out-of-range position
            end
        end else if (syn != '0) begin
            det_dbe = 1'b1;
        end
        fix_data = extract(fix_cw);
    end

    // =====================================================================
    // state: answer and event pulses, all registered
    tse_state_t st_q;
    tse_state_t st_d;
    logic       sbe_ev;
    logic       dbe_ev;

    assign sbe_ev = st_q.rd_pend && prot_on && det_sbe;
    assign dbe_ev = st_q.rd_pend && prot_on && det_dbe;

    // pulses last one cycle since rd_pend is re-evaluated each edge
    // cfg is read in the check cycle, so a change between requests applies to the next answer
    always_comb begin
        st_d              = st_q;
        st_d.rd_pend      = req.valid && !req.write;
        st_d.rsp.valid    = st_q.rd_pend;
        st_d.rsp.rdata    = prot_on ? fix_data : extract(rd_cw);
        st_d.rsp.sbe      = sbe_ev;
        st_d.rsp.dbe      = dbe_ev;
        st_d.rsp.abort    = (sbe_ev && cfg.sbe_abort_en)
                          || (dbe_ev && cfg.dbe_abort_en);
        st_d.evt.agg_sbe  = sbe_ev;
        st_d.evt.agg_dbe  = dbe_ev;
        st_d.evt.agg_sev  = dbe_ev ? SEV_HIGH : (sbe_ev ? SEV_LOW : SEV_NONE);
        st_d.evt.agg_irq  = (sbe_ev && cfg.agg_resp_mask[0])
                          || (dbe_ev && cfg.agg_resp_mask[1]);
        st_d.evt.mon_sbe      = (MEM_CLASS == TSE_MONITOR_TCM) && sbe_ev;
        st_d.evt.main_dbe_irq = (MEM_CLASS == TSE_MONITOR_TCM) && dbe_ev;
        if (!st_q.rd_pend) begin
            st_d.rsp.rdata = st_q.rsp.rdata;   // hold last read data
        end
    end

    // synchronous reset to all zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp = st_q.rsp;
    assign evt = st_q.evt;

    // =====================================================================
    // checks on the block's own outputs
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // raw_q needs no reset: it is only compared while rsp.valid, which is reset
    logic [DATA_W-1:0] raw_q;   // uncorrected data, for comparing with output
    always_ff @(posedge ref_clk) begin
        raw_q <= extract(rd_cw);
    end

    // a read is answered exactly two edges later
    rd_latency_a: assert property (req.valid && !req.write |-> ##2 rsp.valid)
        else $error("read not answered after two cycles");

    // writes produce no answer
    wr_silent_a: assert property (req.valid && req.write && !$past(req.valid) |-> ##2 !rsp.valid)
        else $error("write produced an answer");

    // single and double are never flagged together
    sbe_dbe_excl_a: assert property (!(rsp.sbe && rsp.dbe))
        else $error("single and double error together");

    // corrected word differs from raw data in at most one bit
    one_bit_fix_a: assert property (rsp.valid && rsp.sbe |-> $countones(rsp.rdata ^ raw_q) <= 1)
        else $error("correction changed more than one bit");

    // abort follows the selected response of the error kind
    abort_sel_a: assert property (rsp.valid |-> rsp.abort ==
        ((rsp.sbe && $past(cfg.sbe_abort_en)) || (rsp.dbe && $past(cfg.dbe_abort_en))))
        else $error("abort does not match selected response");

    // each single-bit aggregator pulse is a single cycle
    pulse_width_a: assert property (evt.agg_sbe |=> !evt.agg_sbe || $past(req.valid && !req.write, 2))
        else $error("single error pulse stretched");

    // pulses coincide with a checked answer
    pulse_tie_a: assert property ((evt.agg_sbe || evt.agg_dbe) |-> rsp.valid)
        else $error("error pulse without checked read");

    // double-bit pulses carry high severity
    sev_class_a: assert property (evt.agg_dbe |-> evt.agg_sev == SEV_HIGH)
        else $error("double error not high severity");

    // disabled peripheral protection reports nothing
    periph_off_a: assert property ((MEM_CLASS == TSE_PERIPH_SRAM) && !$past(cfg.periph_en && cfg.agg_en)
        |-> !evt.agg_sbe && !evt.agg_dbe)
        else $error("error reported while protection disabled");

    // monitor routing: single to monitor, double to main
    mon_route_a: assert property ((MEM_CLASS == TSE_MONITOR_TCM) && rsp.valid
        |-> evt.mon_sbe == rsp.sbe && evt.main_dbe_irq == rsp.dbe)
        else $error("monitor memory error routed wrongly");

    // other classes never drive the monitor routing
    mon_quiet_a: assert property ((MEM_CLASS != TSE_MONITOR_TCM) |-> !evt.mon_sbe && !evt.main_dbe_irq)
        else $error("monitor routing from a non-monitor memory");

    // interrupt follows the programmed mask of each severity
    irq_mask_a: assert property (evt.agg_irq ==
        ((evt.agg_sbe && $past(cfg.agg_resp_mask[0])) || (evt.agg_dbe && $past(cfg.agg_resp_mask[1]))))
        else $error("aggregator interrupt does not match mask");

    // single-bit pulses carry low severity
    sev_low_a: assert property (evt.agg_sbe |-> evt.agg_sev == SEV_LOW)
        else $error("single error not low severity");

    // abort only answers a detected error
    abort_cause_a: assert property (rsp.abort |-> rsp.valid && (rsp.sbe || rsp.dbe))
        else $error("abort without detected error");

    // without a single-bit flag the word passes unchanged
    raw_pass_a: assert property (rsp.valid && !rsp.sbe |-> rsp.rdata == raw_q)
        else $error("data altered without single error");

    // read data stands between answers
    rdata_hold_a: assert property (!rsp.valid |-> $stable(rsp.rdata))
        else $error("read data changed without an answer");

    // one answer per read, never a stretched valid
    ans_once_a: assert property (rsp.valid |=> !rsp.valid || $past(req.valid && !req.write, 2))
        else $error("answer without a matching read");

    // main scenarios
    rd_seen_c:  cover property (req.valid && !req.write ##2 rsp.valid);
    sbe_seen_c: cover property (rsp.valid && rsp.sbe);
    dbe_seen_c: cover property (rsp.valid && rsp.dbe && rsp.abort);
    b2b_rd_c:   cover property (rsp.valid [*3]);
    irq_seen_c: cover property (evt.agg_irq && evt.agg_dbe);

endmodule : tse_ecc_path

// ==== bench/tse_core_model.sv ====
// partner: processor core model issuing memory requests and static config
`timescale 1ns/1ns
module tse_core_model
    import tse_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          req_ready,
    output tse_pkg::tse_req_t  req,
    output tse_pkg::tse_cfg_t  cfg
);
    // =====================================================================
    // power-up: protection enabled on both sides by core software
    initial begin
        req = '0;
        cfg = '{1'h0, 1'h1, 1'h1, 1'h1, 2'h3};
    end

    // drive after a falling edge, hold until taken with ready high
    task automatic issue(input logic wr, input logic [15:0] a, input logic [63:0] d);
        @(negedge ref_clk);
        req = '{1'h1, wr, a, d};
        do @(posedge ref_clk); while (req_ready !== 1'h1);
    endtask : issue

    // released bus shows inverted qualifiers, never the stale request
    task automatic idle();
        @(negedge ref_clk);
        req = '{1'h0, ~req.write, ~req.addr, ~req.wdata};
    endtask : idle

    // software reprogramming between transfers
    task automatic set_cfg(input tse_cfg_t c);
        @(negedge ref_clk);
        cfg = c;
    endtask : set_cfg
endmodule : tse_core_model

// ==== bench/tse_ecc_path_test.sv ====
// testbench: three memory classes behind one core model, with bank fault injection
`timescale 1ns/1ns
module tse_ecc_path_test;
    import tse_pkg::*;
    logic       ref_clk     = 1'h0;
    logic       rst_n       = 1'h0;
    tse_req_t   req;
    tse_cfg_t   cfg;
    logic [2:0] ready;
    tse_rsp_t   rsp [3];
    tse_evt_t   evt [3];
    int         err_count   = 0;
    int         comparisons = 0;
    int         cycles      = 0;

    // =====================================================================
    // clock, partner and one design instance per memory class
    always #25 ref_clk = ~ref_clk;
    tse_core_model tse_core_model_inst (.ref_clk(ref_clk), .req_ready(&ready), .req(req), .cfg(cfg));
    for (genvar i = 0; i < 3; i++) begin : g_dut
        tse_ecc_path #(.ADDR_W(10), .MEM_CLASS(tse_class_t'(i))) tse_ecc_path_inst (
            .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_ready(ready[i]),
            .cfg(cfg), .rsp(rsp[i]), .evt(evt[i]));
    end

    // =====================================================================
    // helpers
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // generate scopes need constant indices, hence the case
    task automatic flip(input int i, input int b, input logic [9:0] a, input int n);
        case (i * 2 + b)
            0: g_dut[0].tse_ecc_path_inst.g_bank[0].u_bank.mem[a][n] ^= 1'h1;
            1: g_dut[0].tse_ecc_path_inst.g_bank[1].u_bank.mem[a][n] ^= 1'h1;
            2: g_dut[1].tse_ecc_path_inst.g_bank[0].u_bank.mem[a][n] ^= 1'h1;
            3: g_dut[1].tse_ecc_path_inst.g_bank[1].u_bank.mem[a][n] ^= 1'h1;
            4: g_dut[2].tse_ecc_path_inst.g_bank[0].u_bank.mem[a][n] ^= 1'h1;
            default: g_dut[2].tse_ecc_path_inst.g_bank[1].u_bank.mem[a][n] ^= 1'h1;
        endcase
    endtask : flip

    task automatic wr(input logic [9:0] a, input logic [63:0] d);
        tse_core_model_inst.issue(1'h1, {6'h00, a}, d);
        tse_core_model_inst.idle();
    endtask : wr

    // read on all classes; k: 0 clean, 1 single, 2 double; on: protection active
    task automatic rd_chk(input logic [9:0] a, input logic [63:0] d, input int k, input logic [2:0] on);
        logic [1:0] kk;
        tse_evt_t   ee;
        tse_core_model_inst.issue(1'h0, {6'h00, a}, 64'h0);
        tse_core_model_inst.idle();
        // idle returns half a cycle after the taking edge: no answer yet
        for (int i = 0; i < 3; i++) chk({71'h0, rsp[i].valid}, 72'h0);
        @(negedge ref_clk);
        for (int i = 0; i < 3; i++) begin
            kk = on[i] ? 2'(k) : 2'h0;
            ee = '{kk == 2'h1, kk == 2'h2, kk, kk != 2'h0 && cfg.agg_resp_mask[kk == 2'h2],
                   i == 1 && kk == 2'h1, i == 1 && kk == 2'h2};
            chk({rsp[i].valid, rsp[i].sbe, rsp[i].dbe, rsp[i].abort, evt[i]},
                {1'h1, kk == 2'h1, kk == 2'h2, (kk == 2'h1 && cfg.sbe_abort_en) ||
                 (kk == 2'h2 && cfg.dbe_abort_en), ee});
            if (k == 0 || kk == 2'h1) chk(rsp[i].rdata, d);
        end
        @(negedge ref_clk);
        for (int i = 0; i < 3; i++) chk({rsp[i].valid, rsp[i].sbe, rsp[i].dbe, rsp[i].abort, evt[i]}, 72'h0);
    endtask : rd_chk

    // =====================================================================
    // scenarios
    task automatic t_clean();
        logic [63:0] pat [4] = '{64'h0, ~64'h0, 64'hA5A5_5A5A_F00F_0FF0, 64'h8000_0000_0000_0001};
        for (int j = 0; j < 4; j++) wr(10'(j), pat[j]);
        for (int j = 0; j < 4; j++) rd_chk(10'(j), pat[j], 0, 3'h7);
    endtask : t_clean

    task automatic t_single();
        for (int s = 0; s < 4; s++) begin
            tse_core_model_inst.set_cfg('{s[0], 1'h1, 1'h1, 1'h1, {s[0], ~s[0]}});
            wr(10'h20, 64'h0123_4567_89AB_CDEF);
            for (int i = 0; i < 3; i++) flip(i, s / 2, 10'h20, 3 + s * 9);
            rd_chk(10'h20, 64'h0123_4567_89AB_CDEF, 1, 3'h7);
        end
    endtask : t_single

    task automatic t_double();
        for (int s = 0; s < 2; s++) begin
            tse_core_model_inst.set_cfg('{1'h1, s[0], 1'h1, 1'h1, 2'h2});
            wr(10'h30, 64'hFEDC_BA98_7654_3210);
            for (int i = 0; i < 3; i++) begin
                flip(i, 0, 10'h30, 7);
                flip(i, s, 10'h30, 20);
            end
            rd_chk(10'h30, 64'hFEDC_BA98_7654_3210, 2, 3'h7);
        end
    endtask : t_double

    // a row fetched from the wrong bank address must not pass as clean
    task automatic t_addr();
        wr(10'h05, 64'h0);
        // all-ones gives an odd half that is itself a codeword; one set bit does not
        wr(10'h06, 64'h1);
        g_dut[0].tse_ecc_path_inst.g_bank[1].u_bank.mem[5] = g_dut[0].tse_ecc_path_inst.g_bank[1].u_bank.mem[6];
        tse_core_model_inst.issue(1'h0, 16'h0005, 64'h0);
        tse_core_model_inst.idle();
        @(negedge ref_clk);
        chk({71'h0, rsp[0].sbe | rsp[0].dbe}, 72'h1);
    endtask : t_addr

    // peripheral class stays silent unless both enables are set
    task automatic t_periph();
        for (int s = 0; s < 2; s++) begin
            tse_core_model_inst.set_cfg('{1'h0, 1'h0, s[0], ~s[0], 2'h3});
            wr(10'h40, 64'h5555_AAAA_3333_CCCC);
            for (int i = 0; i < 3; i++) flip(i, 0, 10'h40, 11);
            rd_chk(10'h40, 64'h5555_AAAA_3333_CCCC, 1, 3'h3);
            // unprotected copy returns cell 11 of bank 0 raw: codeword bit 18, data bit 12
            chk(rsp[2].rdata, 64'h5555_AAAA_3333_DCCC);
        end
    endtask : t_periph

    // write then read the same word back to back, answers in consecutive cycles
    task automatic t_b2b();
        wr(10'h08, 64'h1111_2222_3333_4444);
        tse_core_model_inst.issue(1'h1, 16'h0009, 64'h9999_8888_7777_6666);
        tse_core_model_inst.issue(1'h0, 16'h0009, 64'h0);
        tse_core_model_inst.issue(1'h0, 16'h0008, 64'h0);
        tse_core_model_inst.idle();
        chk({rsp[0].valid, rsp[0].rdata}, {1'h1, 64'h9999_8888_7777_6666});
        @(negedge ref_clk);
        chk({rsp[0].valid, rsp[0].rdata}, {1'h1, 64'h1111_2222_3333_4444});
    endtask : t_b2b

    // =====================================================================
    // verdict, watchdog and main sequence
    task automatic results();
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1'h1;
        t_clean();
        t_single();
        t_double();
        t_addr();
        t_periph();
        t_b2b();
        results();
    end
endmodule : tse_ecc_path_test
